//--- port_irq_cfg.svh
// Register offsets, field positions and reset values of the port latch and change interrupt unit
// What this block does
// - Latch read returns latch, not pins
// - Latch write updates pins set as outputs
// - Eight latch bits, read/write, cleared at reset
// - Per-pin enable and per-pin source select
// - Pin-change mode: enabled pin differs from previous
// - Compare mode: enabled pin differs from default
// - Only enabled inputs may cause interrupt
// - Interrupt copies whole port into capture
// - Pending interrupt blocks new ones and recapture
// - Only the selected read clears; writes never
// - Clear only after read data delivered
// - Pending change keeps interrupt set through a clearing read
// - Pin-change reference reloads at each interrupt
// - Compare mismatch keeps interrupt despite reads
// - Interrupt output low, high or open-drain
// - Bit 2 open-drain overrides bit 1 polarity
// - Bit 0 selects capture read or port read
// - Flag register shows causing pins, ignores writes
// - Port read gives pins; port write sets latch
`ifndef PORT_IRQ_CFG_SVH
`define PORT_IRQ_CFG_SVH

`define OFS_PIN_DIRECTION        8'h00
`define OFS_CHANGE_IRQ_ENABLE    8'h08
`define OFS_COMPARE_DEFAULT      8'h0C
`define OFS_CHANGE_SOURCE_SELECT 8'h10
`define OFS_EXPANDER_CONFIG      8'h14
`define OFS_IRQ_FLAGS            8'h1C
`define OFS_IRQ_CAPTURE          8'h20
`define OFS_PORT                 8'h24
`define OFS_OUTPUT_LATCH         8'h28

`define BIT_IRQ_CLEAR_SELECT     0
`define BIT_IRQ_POLARITY         1
`define BIT_IRQ_OPEN_DRAIN       2
`define CONFIG_MASK              8'h07

`define RST_PIN_DIRECTION        8'hFF
`define RST_ZERO                 8'h00
`define SYNC_STAGES              2

`endif

//--- port_irq_pkg.sv
// Types shared by the port latch and change interrupt unit
package port_irq_pkg;

    typedef logic [7:0] port_type;

    typedef enum logic [9:0] {
        SEL_NONE      = 10'h001,
        SEL_DIRECTION = 10'h002,
        SEL_ENABLE    = 10'h004,
        SEL_DEFAULT   = 10'h008,
        SEL_SOURCE    = 10'h010,
        SEL_CONFIG    = 10'h020,
        SEL_FLAGS     = 10'h040,
        SEL_CAPTURE   = 10'h080,
        SEL_PORT      = 10'h100,
        SEL_LATCH     = 10'h200
    } reg_sel_type;

endpackage : port_irq_pkg

//--- port_latch_change_interrupt.sv
// Output latch, change detection and interrupt output behind a Wishbone slave
`include "port_irq_cfg.svh"

module port_latch_change_interrupt
    import port_irq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  pin_i,
    output logic      [7:0]  pin_o,
    output logic      [7:0]  pin_oe_n_o,
    output logic             irq_o,
    output logic             irq_oe_n_o
);

    // Bus front end
    reg_sel_type sel;
    logic        take;
    logic        wr;
    logic        rd;

    always_comb
    begin
        case (wb_adr_i)
            `OFS_PIN_DIRECTION:        sel = SEL_DIRECTION;
            `OFS_CHANGE_IRQ_ENABLE:    sel = SEL_ENABLE;
            `OFS_COMPARE_DEFAULT:      sel = SEL_DEFAULT;
            `OFS_CHANGE_SOURCE_SELECT: sel = SEL_SOURCE;
            `OFS_EXPANDER_CONFIG:      sel = SEL_CONFIG;
            `OFS_IRQ_FLAGS:            sel = SEL_FLAGS;
            `OFS_IRQ_CAPTURE:          sel = SEL_CAPTURE;
            `OFS_PORT:                 sel = SEL_PORT;
            `OFS_OUTPUT_LATCH:         sel = SEL_LATCH;
            default:                   sel = SEL_NONE;
        endcase
    end

    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr   = take && wb_we_i && wb_sel_i[0];
    assign rd   = take && !wb_we_i;

    // Registers
    port_type direction_q, direction_d;
    port_type enable_q,    enable_d;
    port_type default_q,   default_d;
    port_type source_q,    source_d;
    port_type config_q,    config_d;
    port_type latch_q,     latch_d;
    port_type flags_q,     flags_d;
    port_type capture_q,   capture_d;
    port_type ref_q,       ref_d;
    port_type sync_q [`SYNC_STAGES];
    port_type sample;
    port_type cond;
    logic     active_q,    active_d;
    logic     clr;
    logic     fire;
    port_type rdata;
    logic     [31:0] dat_d;
    logic     ack_d;
    logic     irq_d;
    logic     irq_oe_n_d;
    logic     [7:0] pin_oe_n_d;

    assign sample = sync_q[`SYNC_STAGES-1];

    // Per-pin interrupt condition
    for (genvar i = 0; i < 8; i++)
    begin : g_cond
        assign cond[i] = enable_q[i] && direction_q[i] &&
            (source_q[i] ? (sample[i] != default_q[i])
                         : (sample[i] != ref_q[i]));
    end

    // Clearing read selected by config bit 0
    assign clr = rd && (config_q[`BIT_IRQ_CLEAR_SELECT]
                        ? (sel == SEL_CAPTURE) : (sel == SEL_PORT));
    assign fire = (|cond) && (!active_q || clr);

    always_comb
    begin
        direction_d = direction_q;
        enable_d    = enable_q;
        default_d   = default_q;
        source_d    = source_q;
        config_d    = config_q;
        latch_d     = latch_q;
        if (wr)
        begin
            case (sel)
                SEL_DIRECTION: direction_d = wb_dat_i[7:0];
                SEL_ENABLE:    enable_d    = wb_dat_i[7:0];
                SEL_DEFAULT:   default_d   = wb_dat_i[7:0];
                SEL_SOURCE:    source_d    = wb_dat_i[7:0];
                SEL_CONFIG:    config_d    = wb_dat_i[7:0] & `CONFIG_MASK;
                SEL_PORT:      latch_d     = wb_dat_i[7:0];
                SEL_LATCH:     latch_d     = wb_dat_i[7:0];
                default:       latch_d     = latch_q;
            endcase
        end
    end

    always_comb
    begin
        active_d  = active_q;
        flags_d   = flags_q;
        capture_d = capture_q;
        ref_d     = active_q ? ref_q : sample;
        if (fire)
        begin
            active_d  = 1'b1;
            flags_d   = cond;
            capture_d = sample;
            ref_d     = sample;
        end
        else if (clr)
        begin
            active_d = 1'b0;
            flags_d  = `RST_ZERO;
        end
    end

    always_comb
    begin
        case (sel)
            SEL_DIRECTION: rdata = direction_q;
            SEL_ENABLE:    rdata = enable_q;
            SEL_DEFAULT:   rdata = default_q;
            SEL_SOURCE:    rdata = source_q;
            SEL_CONFIG:    rdata = config_q;
            SEL_FLAGS:     rdata = flags_q;
            SEL_CAPTURE:   rdata = capture_q;
            SEL_PORT:      rdata = sample;
            SEL_LATCH:     rdata = latch_q;
            default:       rdata = `RST_ZERO;
        endcase
        dat_d = rd ? {24'h000000, rdata} : 32'h00000000;
        ack_d = take;
    end

    // Output pins and interrupt pin shaping
    always_comb
    begin
        pin_oe_n_d = direction_d;
        if (config_d[`BIT_IRQ_OPEN_DRAIN])
        begin
            irq_d      = 1'b0;
            irq_oe_n_d = !active_d;
        end
        else
        begin
            irq_d      = config_d[`BIT_IRQ_POLARITY] ? active_d : !active_d;
            irq_oe_n_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            direction_q <= `RST_PIN_DIRECTION;
            enable_q    <= `RST_ZERO;
            default_q   <= `RST_ZERO;
            source_q    <= `RST_ZERO;
            config_q    <= `RST_ZERO;
            latch_q     <= `RST_ZERO;
            flags_q     <= `RST_ZERO;
            capture_q   <= `RST_ZERO;
            ref_q       <= `RST_ZERO;
            active_q    <= 1'b0;
            wb_dat_o    <= 32'h00000000;
            wb_ack_o    <= 1'b0;
            pin_o       <= `RST_ZERO;
            pin_oe_n_o  <= `RST_PIN_DIRECTION;
            irq_o       <= 1'b1;
            irq_oe_n_o  <= 1'b0;
            for (int k = 0; k < `SYNC_STAGES; k++)
            begin
                sync_q[k] <= `RST_ZERO;
            end
        end
        else
        begin
            direction_q <= direction_d;
            enable_q    <= enable_d;
            default_q   <= default_d;
            source_q    <= source_d;
            config_q    <= config_d;
            latch_q     <= latch_d;
            flags_q     <= flags_d;
            capture_q   <= capture_d;
            ref_q       <= ref_d;
            active_q    <= active_d;
            wb_dat_o    <= dat_d;
            wb_ack_o    <= ack_d;
            pin_o       <= latch_d;
            pin_oe_n_o  <= pin_oe_n_d;
            irq_o       <= irq_d;
            irq_oe_n_o  <= irq_oe_n_d;
            sync_q[0]   <= pin_i;
            for (int k = 1; k < `SYNC_STAGES; k++)
            begin
                sync_q[k] <= sync_q[k-1];
            end
        end
    end

    // Checks
    property p_latch_read;
        @(posedge clk_i) disable iff (rst_i)
        rd && sel == SEL_LATCH |=> wb_ack_o && wb_dat_o[7:0] == $past(latch_q);
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

    property p_latch_write;
        @(posedge clk_i) disable iff (rst_i)
        wr && sel == SEL_LATCH |=> pin_o == $past(wb_dat_i[7:0]) && latch_q == pin_o;
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write lost");

    property p_latch_reset;
        @(posedge clk_i)
        rst_i |=> latch_q == 8'h00 && pin_o == 8'h00;
    endproperty
    a_latch_reset: assert property (p_latch_reset) else $error("latch not cleared");

    property p_inputs_only;
        @(posedge clk_i) disable iff (rst_i)
        $rose(active_q) |-> (flags_q & ~$past(direction_q)) == 8'h00 && flags_q != 8'h00;
    endproperty
    a_inputs_only: assert property (p_inputs_only) else $error("output pin flagged");

    property p_capture;
        @(posedge clk_i) disable iff (rst_i)
        $rose(active_q) |-> capture_q == $past(sample);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        active_q && !clr |=> active_q && $stable(capture_q);
    endproperty
    a_hold: assert property (p_hold) else $error("pending irq disturbed");

    property p_write_no_clear;
        @(posedge clk_i) disable iff (rst_i)
        active_q && wr && (sel == SEL_PORT || sel == SEL_CAPTURE) |=> active_q;
    endproperty
    a_write_no_clear: assert property (p_write_no_clear) else $error("write cleared irq");

    property p_reassert;
        @(posedge clk_i) disable iff (rst_i)
        active_q && clr && |cond |=> active_q && capture_q == $past(sample);
    endproperty
    a_reassert: assert property (p_reassert) else $error("pending change lost");

    property p_open_drain;
        @(posedge clk_i) disable iff (rst_i)
        config_q[`BIT_IRQ_OPEN_DRAIN] |-> !irq_o && irq_oe_n_o == !active_q;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain wrong");

    property p_flags;
        @(posedge clk_i) disable iff (rst_i)
        flags_q != 8'h00 |-> active_q;
    endproperty
    a_flags: assert property (p_flags) else $error("flag without irq");

    property p_change_fire;
        @(posedge clk_i) disable iff (rst_i)
        !active_q && |cond |=> active_q && flags_q == $past(cond);
    endproperty
    a_change_fire: assert property (p_change_fire) else $error("change missed");

    property p_clear;
        @(posedge clk_i) disable iff (rst_i)
        active_q && clr && !(|cond) |=> !active_q && wb_dat_o[7:0] == $past(rdata);
    endproperty
    a_clear: assert property (p_clear) else $error("clearing read wrong");

    property p_ref_reload;
        @(posedge clk_i) disable iff (rst_i)
        $rose(active_q) |-> ref_q == capture_q;
    endproperty
    a_ref_reload: assert property (p_ref_reload) else $error("reference not reloaded");

    property p_push_pull;
        @(posedge clk_i) disable iff (rst_i)
        !config_q[`BIT_IRQ_OPEN_DRAIN] |->
            !irq_oe_n_o && irq_o == (config_q[`BIT_IRQ_POLARITY] ? active_q : !active_q);
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("irq level wrong");

    property p_sync;
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && !$past(rst_i, 2) |-> sample == $past(pin_i, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("pin sample wrong");

endmodule : port_latch_change_interrupt

//--- host_bus_model.sv
// Host side Wishbone classic master for the register bus
module host_bus_model
(
    input  wire logic        clk_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [7:0]  adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // One single cycle, held until ack, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] r);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
        end
        while (ack_i !== 1'b1);
        r = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
endmodule : host_bus_model

//--- port_latch_change_interrupt_test.sv
// Self-checking bench for the port latch and change interrupt unit
`include "port_irq_cfg.svh"
module port_latch_change_interrupt_test;
    import port_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack, irq, irq_oe_n;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    port_type    pin_i = 8'h00;
    port_type    pin_o, pin_oe_n;
    int          err_total = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #20 clk_i = ~clk_i;

    port_latch_change_interrupt port_latch_change_interrupt_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_n_o(pin_oe_n), .irq_o(irq), .irq_oe_n_o(irq_oe_n));

    host_bus_model host_bus_model_i (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    task automatic results;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            err_total++;
            results();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        host_bus_model_i.xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        host_bus_model_i.xfer(1'b0, a, 8'h00, r);
        check(what, r, exp);
    endtask : rdchk

    // Pin change, then enough edges for sync and interrupt update
    task automatic setpin(input port_type v);
        @(posedge clk_i);
        pin_i <= v;
        repeat (4) @(posedge clk_i);
    endtask : setpin

    task automatic t_latch;
        rdchk(`OFS_OUTPUT_LATCH, 32'h00, "latch reset");
        check("oe reset", pin_oe_n, 8'hFF);
        rdchk(8'h04, 32'h00, "unmapped");
        wr(`OFS_PIN_DIRECTION, 8'h00);
        wr(`OFS_OUTPUT_LATCH, 8'hA5);
        setpin(8'h5A);
        rdchk(`OFS_OUTPUT_LATCH, 32'hA5, "latch read");
        check("pin out", pin_o, 8'hA5);
        check("pin oe", pin_oe_n, 8'h00);
        rdchk(`OFS_PORT, 32'h5A, "port read");
        wr(`OFS_PORT, 8'h3C);
        rdchk(`OFS_OUTPUT_LATCH, 32'h3C, "port write");
        check("pin out 2", pin_o, 8'h3C);
        $display("test latch done");
    endtask : t_latch

    task automatic t_change;
        wr(`OFS_PIN_DIRECTION, 8'hFF);
        setpin(8'h00);
        wr(`OFS_CHANGE_IRQ_ENABLE, 8'h01);
        wr(`OFS_CHANGE_SOURCE_SELECT, 8'h00);
        wr(`OFS_EXPANDER_CONFIG, 8'h01);
        setpin(8'h02);
        check("irq disabled pin", irq, 1'b1);
        setpin(8'h03);
        check("irq on change", irq, 1'b0);
        rdchk(`OFS_IRQ_FLAGS, 32'h01, "flags");
        wr(`OFS_IRQ_FLAGS, 8'hFF);
        rdchk(`OFS_IRQ_FLAGS, 32'h01, "flags ro");
        setpin(8'h02);
        rdchk(`OFS_PORT, 32'h02, "port no clear");
        check("irq kept port read", irq, 1'b0);
        wr(`OFS_IRQ_CAPTURE, 8'h00);
        check("irq kept write", irq, 1'b0);
        rdchk(`OFS_IRQ_CAPTURE, 32'h03, "capture");
        check("irq refire", irq, 1'b0);
        rdchk(`OFS_IRQ_CAPTURE, 32'h02, "recapture");
        check("irq cleared", irq, 1'b1);
        wr(`OFS_PIN_DIRECTION, 8'hFE);
        setpin(8'h03);
        check("output pin", irq, 1'b1);
        $display("test change done");
    endtask : t_change

    task automatic t_compare;
        setpin(8'h00);
        wr(`OFS_CHANGE_SOURCE_SELECT, 8'h02);
        wr(`OFS_CHANGE_IRQ_ENABLE, 8'h02);
        wr(`OFS_PIN_DIRECTION, 8'hFF);
        wr(`OFS_EXPANDER_CONFIG, 8'h02);
        check("high idle", irq, 1'b0);
        setpin(8'h02);
        check("high active", irq, 1'b1);
        wr(`OFS_EXPANDER_CONFIG, 8'h06);
        check("od level", irq, 1'b0);
        check("od drive", irq_oe_n, 1'b0);
        wr(`OFS_EXPANDER_CONFIG, 8'h00);
        check("low active", irq, 1'b0);
        rdchk(`OFS_PORT, 32'h02, "port");
        check("mismatch holds", irq, 1'b0);
        setpin(8'h00);
        rdchk(`OFS_PORT, 32'h00, "port 2");
        check("port clear", irq, 1'b1);
        wr(`OFS_EXPANDER_CONFIG, 8'h04);
        check("od release", irq_oe_n, 1'b1);
        wr(`OFS_COMPARE_DEFAULT, 8'h02);
        check("default fire", irq_oe_n, 1'b0);
        rdchk(`OFS_COMPARE_DEFAULT, 32'h02, "default read");
        setpin(8'h02);
        rdchk(`OFS_PORT, 32'h02, "port 3");
        check("default clear", irq_oe_n, 1'b1);
        rdchk(`OFS_EXPANDER_CONFIG, 32'h04, "config read");
        wr(`OFS_EXPANDER_CONFIG, 8'hFF);
        rdchk(`OFS_EXPANDER_CONFIG, 32'h07, "config mask");
        $display("test compare done");
    endtask : t_compare

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_latch();
        t_change();
        t_compare();
        results();
    end
endmodule : port_latch_change_interrupt_test
